// >>> common/smpb_pkg.sv
// package: register numbers, limits, reset values and carrier types of the motor-2 bank
package smpb_pkg;

  localparam int NPAIR   = 9;
  localparam int NSINGLE = 9;

  // register numbers; byte address is four times the number
  localparam logic [15:0] IDX_ACCEL1_TIME_HI         = 16'h2103;
  localparam logic [15:0] IDX_ACCEL1_TIME_LO         = 16'h2104;
  localparam logic [15:0] IDX_DECEL1_TIME_HI         = 16'h2105;
  localparam logic [15:0] IDX_DECEL1_TIME_LO         = 16'h2106;
  localparam logic [15:0] IDX_BASE_FREQ              = 16'h2203;
  localparam logic [15:0] IDX_MAX_FREQ               = 16'h2204;
  localparam logic [15:0] IDX_MULTISPEED_FREQ_HI     = 16'h2216;
  localparam logic [15:0] IDX_MULTISPEED_FREQ_LO     = 16'h2217;
  localparam logic [15:0] IDX_BOOST_METHOD           = 16'h223b;
  localparam logic [15:0] IDX_MANUAL_BOOST_VALUE     = 16'h223c;
  localparam logic [15:0] IDX_MANUAL_BOOST_FREQ_ADJ  = 16'h223d;
  localparam logic [15:0] IDX_CURVE_SELECT           = 16'h223e;
  localparam logic [15:0] IDX_AUTO_BOOST_VOLTAGE_GAIN = 16'h2240;
  localparam logic [15:0] IDX_AUTO_BOOST_SLIP_GAIN   = 16'h2241;
  localparam logic [15:0] IDX_FREQ_UPPER_LIMIT_HI    = 16'h224f;
  localparam logic [15:0] IDX_FREQ_UPPER_LIMIT_LO    = 16'h2250;
  localparam logic [15:0] IDX_FREQ_LOWER_LIMIT_HI    = 16'h2251;
  localparam logic [15:0] IDX_FREQ_LOWER_LIMIT_LO    = 16'h2252;
  localparam logic [15:0] IDX_ACCEL2_TIME_HI         = 16'h226f;
  localparam logic [15:0] IDX_ACCEL2_TIME_LO         = 16'h2270;
  localparam logic [15:0] IDX_DECEL2_TIME_HI         = 16'h2271;
  localparam logic [15:0] IDX_DECEL2_TIME_LO         = 16'h2272;
  localparam logic [15:0] IDX_RAMP_SWITCH_METHOD     = 16'h2273;
  localparam logic [15:0] IDX_ACCEL_TRANSITION_FREQ_HI = 16'h2274;
  localparam logic [15:0] IDX_ACCEL_TRANSITION_FREQ_LO = 16'h2275;
  localparam logic [15:0] IDX_DECEL_TRANSITION_FREQ_HI = 16'h2276;
  localparam logic [15:0] IDX_DECEL_TRANSITION_FREQ_LO = 16'h2277;
  localparam logic [15:0] IDX_STATUS                 = 16'h0001;

  // pair slots
  localparam logic [3:0] P_ACCEL1 = 4'h0;
  localparam logic [3:0] P_DECEL1 = 4'h1;
  localparam logic [3:0] P_MULTI  = 4'h2;
  localparam logic [3:0] P_UPPER  = 4'h3;
  localparam logic [3:0] P_LOWER  = 4'h4;
  localparam logic [3:0] P_ACCEL2 = 4'h5;
  localparam logic [3:0] P_DECEL2 = 4'h6;
  localparam logic [3:0] P_ACC_TR = 4'h7;
  localparam logic [3:0] P_DEC_TR = 4'h8;
  // single slots
  localparam logic [3:0] S_BASE   = 4'h0;
  localparam logic [3:0] S_MAX    = 4'h1;
  localparam logic [3:0] S_BMETH  = 4'h2;
  localparam logic [3:0] S_BVAL   = 4'h3;
  localparam logic [3:0] S_BADJ   = 4'h4;
  localparam logic [3:0] S_CURVE  = 4'h5;
  localparam logic [3:0] S_VGAIN  = 4'h6;
  localparam logic [3:0] S_SGAIN  = 4'h7;
  localparam logic [3:0] S_RAMP   = 4'h8;

  localparam logic [15:0] PAIR_HI_IDX [NPAIR] = '{
    IDX_ACCEL1_TIME_HI, IDX_DECEL1_TIME_HI, IDX_MULTISPEED_FREQ_HI,
    IDX_FREQ_UPPER_LIMIT_HI, IDX_FREQ_LOWER_LIMIT_HI, IDX_ACCEL2_TIME_HI,
    IDX_DECEL2_TIME_HI, IDX_ACCEL_TRANSITION_FREQ_HI, IDX_DECEL_TRANSITION_FREQ_HI};
  localparam logic [15:0] PAIR_LO_IDX [NPAIR] = '{
    IDX_ACCEL1_TIME_LO, IDX_DECEL1_TIME_LO, IDX_MULTISPEED_FREQ_LO,
    IDX_FREQ_UPPER_LIMIT_LO, IDX_FREQ_LOWER_LIMIT_LO, IDX_ACCEL2_TIME_LO,
    IDX_DECEL2_TIME_LO, IDX_ACCEL_TRANSITION_FREQ_LO, IDX_DECEL_TRANSITION_FREQ_LO};
  localparam logic [15:0] SINGLE_IDX [NSINGLE] = '{
    IDX_BASE_FREQ, IDX_MAX_FREQ, IDX_BOOST_METHOD, IDX_MANUAL_BOOST_VALUE,
    IDX_MANUAL_BOOST_FREQ_ADJ, IDX_CURVE_SELECT, IDX_AUTO_BOOST_VOLTAGE_GAIN,
    IDX_AUTO_BOOST_SLIP_GAIN, IDX_RAMP_SWITCH_METHOD};

  // value limits
  localparam logic [31:0] RAMP_TIME_MIN  = 32'h0000_0001;
  localparam logic [31:0] RAMP_TIME_MAX  = 32'h0005_7e40;
  localparam logic [31:0] TRANS_FREQ_MAX = 32'h0000_9c40;
  localparam logic [31:0] HZ_TO_CENTIHZ  = 32'h0000_0064;
  localparam logic [15:0] FREQ_HZ_MIN    = 16'h001e;
  localparam logic [15:0] FREQ_HZ_MAX    = 16'h0190;
  localparam logic [15:0] BOOST_METH_MAX = 16'h0001;
  localparam logic [15:0] BOOST_VAL_MAX  = 16'h00c8;
  localparam logic [15:0] BOOST_ADJ_MAX  = 16'h01f4;
  localparam logic [15:0] CURVE_MAX      = 16'h0004;
  localparam logic [15:0] GAIN_MAX       = 16'h00ff;
  localparam logic [15:0] RAMP_SW_MAX    = 16'h0002;

  // values after reset
  localparam logic [31:0] RST_RAMP_TIME  = 32'h0000_0bb8;
  localparam logic [31:0] RST_PAIR_ZERO  = 32'h0000_0000;
  localparam logic [15:0] RST_FREQ_HZ    = 16'h003c;
  localparam logic [15:0] RST_GAIN       = 16'h0064;
  localparam logic [15:0] RST_ZERO16     = 16'h0000;
  localparam logic [31:0] PAIR_RST [NPAIR] = '{
    RST_RAMP_TIME, RST_RAMP_TIME, RST_PAIR_ZERO, RST_PAIR_ZERO, RST_PAIR_ZERO,
    RST_RAMP_TIME, RST_RAMP_TIME, RST_PAIR_ZERO, RST_PAIR_ZERO};
  localparam logic [15:0] SINGLE_RST [NSINGLE] = '{
    RST_FREQ_HZ, RST_FREQ_HZ, RST_ZERO16, RST_ZERO16, RST_ZERO16,
    RST_ZERO16, RST_GAIN, RST_GAIN, RST_ZERO16};

  // status register fields
  localparam int ST_REJECT   = 0;
  localparam int ST_RESERVED = 1;
  localparam int ST_PEND_LSB = 2;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic [NPAIR-1:0][31:0]   pair;
    logic [NSINGLE-1:0][15:0] single;
  } smpb_params_t;

  typedef struct packed {
    logic [NPAIR-1:0] pend;
    logic             reserved_hit;
    logic             rejected;
  } smpb_status_t;

endpackage

// >>> rtl/smpb_bank.sv
// motor-2 parameter register bank behind an ahb-lite slave
// Function
// - primary accel time pair, 1..360000
// - primary decel time pair, 1..360000
// - base frequency 30 up to max
// - maximum frequency 30 to 400 Hz
// - multispeed zero or start..max frequency
// - boost method 0 manual, 1 auto
// - manual boost value 0 to 200
// - manual boost break frequency 0 to 500
// - curve select codes 0 to 4
// - boost voltage and slip gains 0..255
// - upper limit zero or lower..max
// - lower limit zero or start..max
// - secondary accel time pair, 1..360000
// - secondary decel time pair, 1..360000
// - ramp switch method codes 0 to 2
// - accel transition frequency 0 to 40000
// - decel transition frequency 0 to 40000
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module smpb_bank (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  input  wire logic [15:0]            start_freq,
  output smpb_pkg::smpb_params_t      params,
  output smpb_pkg::smpb_status_t      status
);
  import smpb_pkg::*;

  // decode of a register number: {hit, is_hi, slot}
  function automatic logic [5:0] pair_dec(input logic [15:0] idx);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < NPAIR; i++) begin
      if (idx == PAIR_HI_IDX[i]) begin
        r = {2'b11, i[3:0]};
      end
      if (idx == PAIR_LO_IDX[i]) begin
        r = {2'b10, i[3:0]};
      end
    end
    return r;
  endfunction

  // decode of a single register number: {hit, slot}
  function automatic logic [4:0] single_dec(input logic [15:0] idx);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NSINGLE; i++) begin
      if (idx == SINGLE_IDX[i]) begin
        r = {1'b1, i[3:0]};
      end
    end
    return r;
  endfunction

  // byte address to register number; bit 16 flags an unaligned or out-of-range address
  function automatic logic [16:0] addr_idx(input logic [31:0] a);
    return {(a[31:18] != 14'h0000) || (a[1:0] != 2'b00), a[17:2]};
  endfunction

  logic [NPAIR-1:0][31:0]   pair_q;
  logic [NPAIR-1:0][15:0]   hibuf_q;
  logic [NPAIR-1:0]         pend_q;
  logic [NSINGLE-1:0][15:0] single_q;
  logic                     rejected_q;
  logic                     reserved_q;
  logic                     wr_act_q;
  logic [16:0]              wr_idx_q;
  logic                     rd_act_q;
  logic [16:0]              rd_idx_q;
  logic                     hreadyout_q;
  logic [31:0]              hrdata_q;

  // address phase
  wire        a_take  = hsel && (htrans == HTRANS_NONSEQ) && hready;
  wire [16:0] a_idx   = addr_idx(haddr);

  // write data phase decode
  wire [15:0] wd      = hwdata[15:0];
  wire [5:0]  w_pd    = pair_dec(wr_idx_q[15:0]);
  wire [4:0]  w_sd    = single_dec(wr_idx_q[15:0]);
  wire        w_okadr = wr_act_q && !wr_idx_q[16];
  wire        w_pair  = w_okadr && w_pd[5];
  wire        w_hi    = w_pd[4];
  wire [3:0]  w_pn    = w_pd[3:0];
  wire        w_sing  = w_okadr && w_sd[4];
  wire [3:0]  w_sn    = w_sd[3:0];
  wire        w_stat  = w_okadr && (wr_idx_q[15:0] == IDX_STATUS);
  wire        w_resv  = wr_act_q && !w_pair && !w_sing && !w_stat;

  // limits in 0.01 Hz taken from the live maximum frequency
  wire [31:0] max_chz = {16'h0000, single_q[S_MAX]} * HZ_TO_CENTIHZ;
  wire [31:0] start32 = {16'h0000, start_freq};
  wire [31:0] lower32 = pair_q[P_LOWER];
  wire [31:0] w_comb  = {hibuf_q[w_pn], wd};

  wire ramp_ok  = (w_comb >= RAMP_TIME_MIN) && (w_comb <= RAMP_TIME_MAX);
  wire multi_ok = (w_comb == 32'h0000_0000) || ((w_comb >= start32) && (w_comb <= max_chz));
  wire upper_ok = (w_comb == 32'h0000_0000) || ((w_comb >= lower32) && (w_comb <= max_chz));
  wire lower_ok = (w_comb == 32'h0000_0000) || ((w_comb >= start32) && (w_comb <= max_chz));
  wire trans_ok = w_comb <= TRANS_FREQ_MAX;

  logic pair_ok;
  always_comb begin
    unique case (w_pn)
      P_ACCEL1: pair_ok = ramp_ok;
      P_DECEL1: pair_ok = ramp_ok;
      P_MULTI:  pair_ok = multi_ok;
      P_UPPER:  pair_ok = upper_ok;
      P_LOWER:  pair_ok = lower_ok;
      P_ACCEL2: pair_ok = ramp_ok;
      P_DECEL2: pair_ok = ramp_ok;
      P_ACC_TR: pair_ok = trans_ok;
      P_DEC_TR: pair_ok = trans_ok;
      default:  pair_ok = 1'b0;
    endcase
  end

  logic single_ok;
  always_comb begin
    unique case (w_sn)
      S_BASE:  single_ok = (wd >= FREQ_HZ_MIN) && (wd <= single_q[S_MAX]);
      S_MAX:   single_ok = (wd >= FREQ_HZ_MIN) && (wd <= FREQ_HZ_MAX);
      S_BMETH: single_ok = wd <= BOOST_METH_MAX;
      S_BVAL:  single_ok = wd <= BOOST_VAL_MAX;
      S_BADJ:  single_ok = wd <= BOOST_ADJ_MAX;
      S_CURVE: single_ok = wd <= CURVE_MAX;
      S_VGAIN: single_ok = wd <= GAIN_MAX;
      S_SGAIN: single_ok = wd <= GAIN_MAX;
      S_RAMP:  single_ok = wd <= RAMP_SW_MAX;
      default: single_ok = 1'b0;
    endcase
  end

  // low half without a held high half is refused
  wire lo_bad   = w_pair && !w_hi && !(pend_q[w_pn] && pair_ok);
  wire sing_bad = w_sing && !single_ok;
  wire set_rej  = lo_bad || sing_bad;

  // read decode, taken one cycle after the address phase
  wire [5:0]  r_pd    = pair_dec(rd_idx_q[15:0]);
  wire [4:0]  r_sd    = single_dec(rd_idx_q[15:0]);
  wire        r_okadr = !rd_idx_q[16];
  wire        r_stat  = r_okadr && (rd_idx_q[15:0] == IDX_STATUS);
  wire [31:0] r_pval  = pair_q[r_pd[3:0]];
  wire [15:0] r_word  = r_pd[4] ? r_pval[31:16] : r_pval[15:0];
  wire [15:0] st_word = {{(16 - NPAIR - 2){1'b0}}, pend_q, reserved_q, rejected_q};
  wire        r_resv  = rd_act_q && !(r_okadr && (r_pd[5] || r_sd[4] || r_stat));
  wire [31:0] r_data  = !r_okadr ? 32'h0000_0000 :
                        r_pd[5]  ? {16'h0000, r_word} :
                        r_sd[4]  ? {16'h0000, single_q[r_sd[3:0]]} :
                        r_stat   ? {16'h0000, st_word} : 32'h0000_0000;

  // bus phase tracking; reads insert one wait state so a prior write is seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_act_q    <= 1'b0;
      wr_idx_q    <= 17'h00000;
      rd_act_q    <= 1'b0;
      rd_idx_q    <= 17'h00000;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
    end else begin
      wr_act_q    <= a_take && hwrite;
      wr_idx_q    <= a_idx;
      rd_act_q    <= a_take && !hwrite;
      rd_idx_q    <= a_idx;
      hreadyout_q <= !(a_take && !hwrite);
      if (rd_act_q) begin
        hrdata_q <= r_data;
      end
    end
  end

  // pair storage with held high half
  genvar g;
  generate
    for (g = 0; g < NPAIR; g++) begin : g_pair
      wire sel = w_pair && (w_pn == 4'(g));
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          pair_q[g]  <= PAIR_RST[g];
          hibuf_q[g] <= 16'h0000;
          pend_q[g]  <= 1'b0;
        end else if (sel && w_hi) begin
          hibuf_q[g] <= wd;
          pend_q[g]  <= 1'b1;
        end else if (sel) begin
          pend_q[g] <= 1'b0;
          if (pend_q[g] && pair_ok) begin
            pair_q[g] <= w_comb;
          end
        end
      end
    end
    for (g = 0; g < NSINGLE; g++) begin : g_single
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          single_q[g] <= SINGLE_RST[g];
        end else if (w_sing && (w_sn == 4'(g)) && single_ok) begin
          single_q[g] <= wd;
        end
      end
    end
  endgenerate

  // sticky flags, a write of one clears, a new event wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rejected_q <= 1'b0;
      reserved_q <= 1'b0;
    end else begin
      rejected_q <= set_rej || (rejected_q && !(w_stat && wd[ST_REJECT]));
      reserved_q <= w_resv || r_resv || (reserved_q && !(w_stat && wd[ST_RESERVED]));
    end
  end

  // registered outputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      params <= '0;
      status <= '0;
    end else begin
      params.pair   <= pair_q;
      params.single <= single_q;
      status        <= '{pend: pend_q, reserved_hit: reserved_q, rejected: rejected_q};
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0;

endmodule

// >>> test/smpb_bank_asserts.sv
// checker: bus answer and parameter range assertions of the bank
`timescale 1ns/1ps
module smpb_bank_asserts
  import smpb_pkg::*;
(
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [2:0]       hsize,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic [15:0]      start_freq,
  input smpb_pkg::smpb_params_t params,
  input smpb_pkg::smpb_status_t status
);
  function automatic logic mapped(logic [31:0] a);
    logic m;
    m = a[17:2] == IDX_STATUS;
    for (int i = 0; i < NPAIR; i++)
      m = m | a[17:2] == PAIR_HI_IDX[i] | a[17:2] == PAIR_LO_IDX[i] | a[17:2] == SINGLE_IDX[i];
    return m && a[31:18] == 14'h0 && a[1:0] == 2'b00;
  endfunction

  wire logic tk  = hsel && htrans == HTRANS_NONSEQ && hready;
  wire logic unm = !mapped(haddr);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_zero_read;
    !hreadyout ##1 (hreadyout && hrdata == 32'h0);
  endsequence
  property p_settled(logic c);
    !$past(reset) |-> c;
  endproperty

  chk_reserved_read: assert property (tk && !hwrite && unm |=> s_zero_read)
    else $error("reserved read not answered with zero after one wait");
  chk_reserved_flag: assert property (tk && unm |-> ##[1:3] status.reserved_hit)
    else $error("reserved access not flagged");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_max_range: assert property (p_settled(params.single[S_MAX] inside {[30:400]}))
    else $error("maximum frequency out of range");
  chk_base_range: assert property (p_settled(params.single[S_BASE] inside {[30:400]}))
    else $error("base frequency out of range");
  chk_code_range: assert property (p_settled(params.single[S_BMETH] <= 1 &&
    params.single[S_CURVE] <= 4 && params.single[S_RAMP] <= 2))
    else $error("mode code out of range");
  chk_boost_range: assert property (p_settled(params.single[S_BVAL] <= 200 &&
    params.single[S_BADJ] <= 500)) else $error("boost value out of range");
  chk_gain_range: assert property (p_settled(params.single[S_VGAIN] <= 255 &&
    params.single[S_SGAIN] <= 255)) else $error("gain out of range");
  chk_time_range: assert property (p_settled(
    params.pair[P_ACCEL1] inside {[1:360000]} && params.pair[P_DECEL1] inside {[1:360000]} &&
    params.pair[P_ACCEL2] inside {[1:360000]} && params.pair[P_DECEL2] inside {[1:360000]}))
    else $error("ramp time out of range");
  chk_trans_range: assert property (p_settled(params.pair[P_ACC_TR] <= 40000 &&
    params.pair[P_DEC_TR] <= 40000)) else $error("transition frequency out of range");
endmodule

bind smpb_bank smpb_bank_asserts i_chk (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .start_freq(start_freq),
  .params(params), .status(status));

// >>> test/smpb_host.sv
// host model: ahb-lite master issuing single word transfers
`timescale 1ns/1ps
module smpb_host
  import smpb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  int errs = 0;
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (!hready && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) errs++;
  endtask

  // called just after a rising edge
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {14'h0, idx, 2'b00};
    hwrite <= w;
    hsize  <= 3'h2;
    hwdata <= ~hwdata;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr_pair(input int s, input logic [31:0] v);
    logic [31:0] d;
    xfer(1'b1, PAIR_HI_IDX[s], {16'h0, v[31:16]}, d);
    xfer(1'b1, PAIR_LO_IDX[s], {16'h0, v[15:0]}, d);
  endtask
endmodule

// >>> test/smpb_bank_tb.sv
// testbench: corner and random accesses to the motor-2 bank
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (e)); end end
module smpb_bank_tb;
  import smpb_pkg::*;
  localparam logic [15:0] RSV [5] = '{16'h2107, 16'h2202, 16'h223f, 16'h2253, 16'h2278};
  logic         clk, reset, hsel, hwrite, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata, seed, sf, d, h;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [15:0]  start_freq;
  logic [31:0]  mp [NPAIR];
  logic [15:0]  ms [NSINGLE];
  smpb_params_t params;
  smpb_status_t status;
  int           miscompares, num_checks;

  smpb_host i_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  smpb_bank i_dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .start_freq(start_freq), .params(params), .status(status));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] lim(logic pr, int s);
    if (!pr) return s == 1 ? 400 : s == 0 ? ms[1] : s == 2 ? 1 : s == 3 ? 200 : s == 4 ? 500
      : s == 5 ? 4 : s == 8 ? 2 : 255;
    return s inside {0, 1, 5, 6} ? 360000 : s > 6 ? 40000 : ms[1] * 100;
  endfunction
  function automatic logic ok(logic pr, int s, logic [31:0] v);
    logic [31:0] lo;
    lo = !pr ? (s < 2 ? 30 : 0) : s inside {0, 1, 5, 6} ? 1 : s == 3 ? mp[4] : s > 6 ? 0 : sf;
    return (v >= lo && v <= lim(pr, s)) || (pr && s inside {2, 3, 4} && v == 0);
  endfunction

  task automatic readback(input logic pr, input int s);
    if (pr) begin
      i_host.xfer(1'b0, PAIR_HI_IDX[s], rnd(), h);
      i_host.xfer(1'b0, PAIR_LO_IDX[s], rnd(), d);
      `CHK({h[15:0], d[15:0]}, mp[s])
      `CHK(params.pair[s], mp[s])
    end else begin
      i_host.xfer(1'b0, SINGLE_IDX[s], rnd(), d);
      `CHK(d, {16'h0, ms[s]})
      `CHK(params.single[s], ms[s])
    end
  endtask
  task automatic trial(input logic pr, input int s, input logic [31:0] v);
    logic e;
    e = ok(pr, s, v);
    i_host.xfer(1'b1, IDX_STATUS, 32'h3, d);
    if (pr) i_host.wr_pair(s, v);
    else i_host.xfer(1'b1, SINGLE_IDX[s], v, d);
    if (e && pr) mp[s] = v;
    if (e && !pr) ms[s] = v[15:0];
    readback(pr, s);
    `CHK(status.rejected, !e)
  endtask
  task automatic give_verdict();
    miscompares += i_host.errs;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    for (int n = 0; n < 30000 && i_host.errs == 0; n++) begin
      @(posedge clk);
    end
    miscompares++;
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    start_freq = 16'h0;
    seed = 32'ha7d8387f;
    miscompares = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    sf = rnd() % 3000;
    reset <= 1'b0;
    start_freq <= sf[15:0];
    @(posedge clk);
    for (int s = 0; s < NPAIR; s++) begin
      mp[s] = PAIR_RST[s];
      ms[s] = SINGLE_RST[s];
      readback(1'b1, s);
      readback(1'b0, s);
    end
    $display("test reset values done");
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 9; s++)
        for (int k = 0; k < 6; k++) begin
          d = lim(p[0], s);
          trial(p[0], s, k == 0 ? d : k == 1 ? d + 1 : k == 2 ? 32'h0 : rnd() % (2 * d + 2));
        end
    $display("test ranges done");
    i_host.xfer(1'b1, IDX_STATUS, 32'h3, d);
    i_host.xfer(1'b1, PAIR_HI_IDX[0], rnd(), d);
    i_host.xfer(1'b0, IDX_STATUS, 32'h0, d);
    `CHK(d[2], 1'b1)
    `CHK(status.pend[0], 1'b1)
    readback(1'b1, 0);
    i_host.xfer(1'b1, PAIR_LO_IDX[1], 32'h1, d);
    readback(1'b1, 1);
    `CHK(status.rejected, 1'b1)
    $display("test half pairs done");
    for (int i = 0; i < 5; i++) begin
      i_host.xfer(1'b1, IDX_STATUS, 32'h3, d);
      i_host.xfer(1'b1, RSV[i], rnd(), d);
      i_host.xfer(1'b0, RSV[i], rnd(), d);
      `CHK(d, 32'h0)
      `CHK(status.reserved_hit, 1'b1)
    end
    $display("test reserved done");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    ms[1] = SINGLE_RST[1];
    readback(1'b0, 1);
    $display("test second reset done");
    give_verdict();
  end
endmodule
